// *** src/dpc_pkg.sv ***
package dpc_pkg;
    localparam int          CHANNELS      = 3;
    localparam int          RW_BIT        = 31;
    localparam int          CODE_MSB      = 30;
    localparam int          CODE_LSB      = 27;
    localparam int          CHAN_MSB      = 25;
    localparam int          CHAN_LSB      = 24;
    localparam logic [3:0]  CODE_DITHER   = 4'h3;
    localparam logic [3:0]  CODE_LIMIT    = 4'h4;
    localparam logic [3:0]  CODE_PERIOD   = 4'h5;
    localparam int          DITH_EN_BIT   = 23;
    localparam int          ALIGN_BIT     = 22;
    localparam int          FBSEL_BIT     = 21;
    localparam int          STEPS_LSB     = 10;
    localparam int          AMP_LSB       = 0;
    localparam int          HI_LSB        = 12;
    localparam int          LO_LSB        = 0;
    localparam int          KI_LSB        = 20;
    localparam int          PERIOD_LSB    = 0;
    localparam logic [11:0] LIMIT_RST     = 12'h7ff;
    localparam logic [2:0]  KI_RST        = 3'h2;
    localparam logic [2:0]  KI_MAX        = 3'h6;
    localparam logic [2:0]  KI_OVER       = 3'h7;
    localparam int          LIMIT_SHIFT   = 5;
    localparam int          PERIOD_SHIFT  = 4;
    localparam int          DIV_W         = 22;

    typedef struct packed {
        logic        dith_en;
        logic        align;
        logic        feedback_report_select;
        logic [5:0]  steps;
        logic [5:0]  amp;
        logic [11:0] hi_lim;
        logic [11:0] lo_lim;
        logic [2:0]  integral_gain_shift;
        logic [11:0] period;
    } dpc_chan_cfg_t;

    localparam dpc_chan_cfg_t CFG_RST = '{
        dith_en: 1'b0, align: 1'b0, feedback_report_select: 1'b0,
        steps: 6'h00, amp: 6'h00, hi_lim: LIMIT_RST, lo_lim: LIMIT_RST,
        integral_gain_shift: KI_RST, period: 12'h000};
endpackage

// *** src/dpc_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bit 31 selects write; reads return it zero
// - Dither enable per selected output, reset off
// - Alignment bit starts dither at switching start
// - Feedback select picks reported measurement set
// - Six-bit quarter-cycle step count, reset zero
// - Six-bit dither amplitude step, reset zero
// - Upper clamp resets 7ff, applied times 32
// - Lower clamp resets 7ff, applied times -32
// - Gain shift saturates, written 7 stored 6
// - Gain shift resets to two
// - Period count is sixteen system clocks each
// - Step rate is clock over (M+1)*2^N
module dpc_bank
    import dpc_pkg::*;
#(
    parameter int NCH = CHANNELS
) (
    input  wire logic                CORE_CLK,
    input  wire logic                RESET_N,
    input  wire logic                CMD_VALID,
    input  wire logic [31:0]         CMD_WORD,
    input  wire logic [5:0]          DIV_MANT,
    input  wire logic [3:0]          DIV_EXP,
    input  wire logic [NCH-1:0]      PWM_CYCLE_START,
    output var  logic                RESP_VALID,
    output var  logic [31:0]         RESP_WORD,
    output var  dpc_chan_cfg_t       CHAN_CFG [NCH],
    output var  logic signed [17:0]  INT_POS_LIMIT [NCH],
    output var  logic signed [17:0]  INT_NEG_LIMIT [NCH],
    output var  logic [15:0]         PERIOD_CYCLES [NCH],
    output var  logic                DITHER_STEP_TICK,
    output var  logic [NCH-1:0]      DITHER_LAUNCH
);
    function automatic logic chan_hit(input logic [31:0] w, input int ch);
        return w[CHAN_MSB:CHAN_LSB] == 2'(ch);
    endfunction

    function automatic logic [2:0] ki_sat(input logic [2:0] k);
        return (k == KI_OVER) ? KI_MAX : k;
    endfunction

    logic                cmd_wr;
    logic                cmd_rd;
    logic [3:0]          cmd_code;
    logic [DIV_W-1:0]    div_cnt_r;
    logic [DIV_W-1:0]    div_lim;
    logic [NCH-1:0]      pend_r;

    assign cmd_code = CMD_WORD[CODE_MSB:CODE_LSB];
    assign cmd_wr   = CMD_VALID && CMD_WORD[RW_BIT];
    assign cmd_rd   = CMD_VALID && !CMD_WORD[RW_BIT];

    // Writes to unmapped channel code 11, or with an unknown command code, fall through untouched
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        always_ff @(posedge CORE_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                CHAN_CFG[i] <= CFG_RST;
            end else if (cmd_wr && chan_hit(CMD_WORD, i)) begin
                case (cmd_code)
                    CODE_DITHER: begin
                        CHAN_CFG[i].dith_en <= CMD_WORD[DITH_EN_BIT];
                        CHAN_CFG[i].align <= CMD_WORD[ALIGN_BIT];
                        CHAN_CFG[i].feedback_report_select <= CMD_WORD[FBSEL_BIT];
                        CHAN_CFG[i].steps <= CMD_WORD[STEPS_LSB+:6];
                        CHAN_CFG[i].amp <= CMD_WORD[AMP_LSB+:6];
                    end
                    CODE_LIMIT: begin
                        CHAN_CFG[i].hi_lim <= CMD_WORD[HI_LSB+:12];
                        CHAN_CFG[i].lo_lim <= CMD_WORD[LO_LSB+:12];
                    end
                    CODE_PERIOD: begin
                        CHAN_CFG[i].integral_gain_shift <= ki_sat(CMD_WORD[KI_LSB+:3]);
                        CHAN_CFG[i].period <= CMD_WORD[PERIOD_LSB+:12];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Applied values registered so downstream sees clean flops
        always_ff @(posedge CORE_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                // Show the scaled reset clamps so no zero limit escapes reset
                INT_POS_LIMIT[i] <= signed'({1'b0, LIMIT_RST, 5'h00});
                INT_NEG_LIMIT[i] <= -signed'({1'b0, LIMIT_RST, 5'h00});
                PERIOD_CYCLES[i] <= 16'h0000;
            end else begin
                INT_POS_LIMIT[i] <= signed'({1'b0, CHAN_CFG[i].hi_lim, 5'h00});
                INT_NEG_LIMIT[i] <= -signed'({1'b0, CHAN_CFG[i].lo_lim, 5'h00});
                PERIOD_CYCLES[i] <= {CHAN_CFG[i].period, 4'h0};
            end
        end

        // Enabling write arms a launch; aligned mode waits for a switching start
        always_ff @(posedge CORE_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                pend_r[i] <= 1'b0;
                DITHER_LAUNCH[i] <= 1'b0;
            end else begin
                DITHER_LAUNCH[i] <= 1'b0;
                if (pend_r[i] && CHAN_CFG[i].dith_en
                    && (!CHAN_CFG[i].align || PWM_CYCLE_START[i])) begin
                    DITHER_LAUNCH[i] <= 1'b1;
                    pend_r[i] <= 1'b0;
                end else if (!CHAN_CFG[i].dith_en) begin
                    pend_r[i] <= 1'b0;
                end
                // Set beats clear when a new enable arrives in the same cycle
                if (cmd_wr && cmd_code == CODE_DITHER && chan_hit(CMD_WORD, i)
                    && CMD_WORD[DITH_EN_BIT]) begin
                    pend_r[i] <= 1'b1;
                end
            end
        end
    end

    // Step prescaler; the divisor is reread every clock so changes apply at once
    assign div_lim = DIV_W'((DIV_W'(DIV_MANT) + DIV_W'(1)) << DIV_EXP);

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_cnt_r        <= '0;
            DITHER_STEP_TICK <= 1'b0;
        end else if (div_cnt_r >= div_lim - DIV_W'(1)) begin
            div_cnt_r        <= '0;
            DITHER_STEP_TICK <= 1'b1;
        end else begin
            div_cnt_r        <= div_cnt_r + DIV_W'(1);
            DITHER_STEP_TICK <= 1'b0;
        end
    end

    logic [31:0] rd_data;
    logic [1:0]  rd_ch;
    dpc_chan_cfg_t rd_cfg;

    assign rd_ch = CMD_WORD[CHAN_MSB:CHAN_LSB];

    always_comb begin
        rd_cfg  = CFG_RST;
        rd_data = 32'h0000_0000;
        for (int k = 0; k < NCH; k++) begin
            if (chan_hit(CMD_WORD, k)) begin
                rd_cfg = CHAN_CFG[k];
            end
        end
        rd_data[CODE_MSB:CODE_LSB] = cmd_code;
        rd_data[CHAN_MSB:CHAN_LSB] = rd_ch;
        case (cmd_code)
            CODE_DITHER: begin
                rd_data[DITH_EN_BIT]    = rd_cfg.dith_en;
                rd_data[ALIGN_BIT]      = rd_cfg.align;
                rd_data[FBSEL_BIT]      = rd_cfg.feedback_report_select;
                rd_data[STEPS_LSB+:6]   = rd_cfg.steps;
                rd_data[AMP_LSB+:6]     = rd_cfg.amp;
            end
            CODE_LIMIT: begin
                rd_data[HI_LSB+:12]     = rd_cfg.hi_lim;
                rd_data[LO_LSB+:12]     = rd_cfg.lo_lim;
            end
            CODE_PERIOD: begin
                rd_data[KI_LSB+:3]      = rd_cfg.integral_gain_shift;
                rd_data[PERIOD_LSB+:12] = rd_cfg.period;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESP_VALID <= 1'b0;
            RESP_WORD  <= 32'h0000_0000;
        end else begin
            RESP_VALID <= cmd_rd && (cmd_code == CODE_DITHER || cmd_code == CODE_LIMIT
                                     || cmd_code == CODE_PERIOD);
            RESP_WORD  <= cmd_rd ? rd_data : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    logic [DIV_W-1:0] tick_gap_r;
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_gap_r <= '0;
        end else begin
            tick_gap_r <= DITHER_STEP_TICK ? DIV_W'(1) : tick_gap_r + DIV_W'(1);
        end
    end

    a_read_flag_zero: assert property (RESP_VALID |-> !RESP_WORD[RW_BIT])
        else $error("read answer carries write flag");
    a_dither_en_write: assert property (cmd_wr && cmd_code == CODE_DITHER
        && chan_hit(CMD_WORD, 0) |=> CHAN_CFG[0].dith_en == $past(CMD_WORD[DITH_EN_BIT]))
        else $error("dither enable not stored");
    a_launch_aligned: assert property (DITHER_LAUNCH[0] && CHAN_CFG[0].align
        && $stable(CHAN_CFG[0].align) |-> $past(PWM_CYCLE_START[0]))
        else $error("aligned launch outside switching start");
    a_fbsel_write: assert property (cmd_wr && cmd_code == CODE_DITHER
        && chan_hit(CMD_WORD, 1) |=> CHAN_CFG[1].feedback_report_select
        == $past(CMD_WORD[FBSEL_BIT]))
        else $error("feedback select not stored");
    a_steps_amp: assert property (cmd_wr && cmd_code == CODE_DITHER && chan_hit(CMD_WORD, 2)
        |=> CHAN_CFG[2].steps == $past(CMD_WORD[15:10])
        && CHAN_CFG[2].amp == $past(CMD_WORD[5:0]))
        else $error("step fields not stored");
    a_pos_limit: assert property (##1 INT_POS_LIMIT[0]
        == 18'sd32 * signed'({6'h00, $past(CHAN_CFG[0].hi_lim)}))
        else $error("positive limit not 32 times clamp");
    a_neg_limit: assert property (##1 INT_NEG_LIMIT[1]
        == -18'sd32 * signed'({6'h00, $past(CHAN_CFG[1].lo_lim)}))
        else $error("negative limit not -32 times clamp");
    a_ki_saturate: assert property (cmd_wr && cmd_code == CODE_PERIOD && chan_hit(CMD_WORD, 0)
        && CMD_WORD[22:20] == 3'h7 |=> CHAN_CFG[0].integral_gain_shift == 3'h6)
        else $error("gain shift seven not stored as six");
    a_ki_reset: assert property ($rose(RESET_N) |-> CHAN_CFG[2].integral_gain_shift == 3'h2)
        else $error("gain shift reset value wrong");
    a_period_scale: assert property (##1 PERIOD_CYCLES[2]
        == {$past(CHAN_CFG[2].period), 4'h0})
        else $error("period not sixteen clocks per count");
    a_tick_spacing: assert property (DITHER_STEP_TICK && $stable(DIV_MANT) && $stable(DIV_EXP)
        && tick_gap_r > DIV_W'(1) |-> tick_gap_r == div_lim)
        else $error("step tick spacing wrong");
    a_other_chan: assert property (cmd_wr && chan_hit(CMD_WORD, 1)
        |=> $stable(CHAN_CFG[0]) && $stable(CHAN_CFG[2]))
        else $error("write touched another channel");

    // Field storage on the remaining channels
    a_amp_write: assert property (cmd_wr && cmd_code == CODE_DITHER
        && chan_hit(CMD_WORD, 0) |=> CHAN_CFG[0].amp == $past(CMD_WORD[5:0]))
        else $error("amplitude step not stored");
    a_align_write: assert property (cmd_wr && cmd_code == CODE_DITHER
        && chan_hit(CMD_WORD, 1) |=> CHAN_CFG[1].align == $past(CMD_WORD[ALIGN_BIT]))
        else $error("alignment bit not stored");
    a_hi_write: assert property (cmd_wr && cmd_code == CODE_LIMIT
        && chan_hit(CMD_WORD, 2) |=> CHAN_CFG[2].hi_lim == $past(CMD_WORD[23:12]))
        else $error("upper clamp not stored");
    a_lo_write: assert property (cmd_wr && cmd_code == CODE_LIMIT
        && chan_hit(CMD_WORD, 2) |=> CHAN_CFG[2].lo_lim == $past(CMD_WORD[11:0]))
        else $error("lower clamp not stored");
    a_period_write: assert property (cmd_wr && cmd_code == CODE_PERIOD
        && chan_hit(CMD_WORD, 0) |=> CHAN_CFG[0].period == $past(CMD_WORD[11:0]))
        else $error("period not stored");
    a_ki_pass: assert property (cmd_wr && cmd_code == CODE_PERIOD
        && chan_hit(CMD_WORD, 1) && CMD_WORD[22:20] != 3'h7
        |=> CHAN_CFG[1].integral_gain_shift == $past(CMD_WORD[22:20]))
        else $error("legal gain shift altered");

    // Answer timing on the command bus
    a_resp_idle: assert property (!$past(CMD_VALID) |-> !RESP_VALID)
        else $error("answer without a command");
    a_write_silent: assert property ($past(cmd_wr) |-> !RESP_VALID)
        else $error("write produced an answer");
    a_resp_code: assert property (RESP_VALID
        |-> RESP_WORD[CODE_MSB:CODE_LSB] == $past(cmd_code))
        else $error("answer carries wrong code");

    // Launch and prescaler behaviour
    a_launch_free: assert property (pend_r[2] && CHAN_CFG[2].dith_en
        && !CHAN_CFG[2].align |=> DITHER_LAUNCH[2])
        else $error("free running launch missing");
    a_launch_needs_en: assert property (DITHER_LAUNCH[2]
        |-> $past(CHAN_CFG[2].dith_en))
        else $error("launch while dither disabled");
    a_tick_single: assert property (DITHER_STEP_TICK
        && div_lim > DIV_W'(1) |=> !DITHER_STEP_TICK)
        else $error("step tick wider than one cycle");
    // Code 11 names no output, so nothing may move
    a_chan3_ignored: assert property (cmd_wr
        && CMD_WORD[CHAN_MSB:CHAN_LSB] == 2'h3
        |=> $stable(CHAN_CFG[0]) && $stable(CHAN_CFG[1]) && $stable(CHAN_CFG[2]))
        else $error("unmapped channel write stored");

    c_dither_launch: cover property (DITHER_LAUNCH[0] && CHAN_CFG[0].align);
    c_read_limit: cover property (cmd_rd && cmd_code == CODE_LIMIT ##1 RESP_VALID);
    c_ki_clamp: cover property (cmd_wr && cmd_code == CODE_PERIOD && CMD_WORD[22:20] == 3'h7);
    c_step_tick: cover property (DITHER_STEP_TICK);
    c_launch_free: cover property (DITHER_LAUNCH[2] && !CHAN_CFG[2].align);
endmodule
`default_nettype wire

// *** verification/dpc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpc_host_model
    import dpc_pkg::*;
(
    input  wire logic        CORE_CLK,
    output var  logic        CMD_VALID,
    output var  logic [31:0] CMD_WORD
);
    initial begin
        CMD_VALID = 1'b0;
        CMD_WORD  = 32'h0000_0000;
    end
    // Released bus shows the inverted word, never a stale copy
    task automatic cmd(input logic [31:0] w);
        logic [31:0] v;
        v = w;
        if (v[31] && v[CODE_MSB:CODE_LSB] == CODE_DITHER && v[15:10] * v[5:0] > 1023)
            v[5:0] = 6'h00;
        @(posedge CORE_CLK);
        CMD_VALID <= 1'b1;
        CMD_WORD  <= v;
        @(posedge CORE_CLK);
        CMD_VALID <= 1'b0;
        CMD_WORD  <= ~v;
    endtask
endmodule
`default_nettype wire

// *** verification/dither_and_period_config_bank_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
        end \
    end
module dither_and_period_config_bank_test
    import dpc_pkg::*;
;
    logic               core_clk;
    logic               reset_n;
    logic               cmd_valid;
    logic [31:0]        cmd_word;
    logic [5:0]         div_mant;
    logic [3:0]         div_exp;
    logic [2:0]         cycle_start;
    logic               resp_valid;
    logic [31:0]        resp_word;
    dpc_chan_cfg_t      chan_cfg [3];
    logic signed [17:0] pos_lim [3];
    logic signed [17:0] neg_lim [3];
    logic [15:0]        period_cyc [3];
    logic               step_tick;
    logic [2:0]         launch;
    int                 n_mismatch;
    int                 checks;
    int                 cycles;
    int                 gap;
    logic [31:0]        rows [5][2];

    dpc_host_model u_dpc_host_model (.CORE_CLK(core_clk), .CMD_VALID(cmd_valid),
        .CMD_WORD(cmd_word));
    dpc_bank u_dpc_bank (.CORE_CLK(core_clk), .RESET_N(reset_n), .CMD_VALID(cmd_valid),
        .CMD_WORD(cmd_word), .DIV_MANT(div_mant), .DIV_EXP(div_exp),
        .PWM_CYCLE_START(cycle_start), .RESP_VALID(resp_valid), .RESP_WORD(resp_word),
        .CHAN_CFG(chan_cfg), .INT_POS_LIMIT(pos_lim), .INT_NEG_LIMIT(neg_lim),
        .PERIOD_CYCLES(period_cyc), .DITHER_STEP_TICK(step_tick), .DITHER_LAUNCH(launch));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic rd_chk(input logic [31:0] exp);
        u_dpc_host_model.cmd({1'b0, exp[30:24], 24'h000000});
        #1;
        `CHK("resp_valid", 1'b1, resp_valid)
        `CHK("resp_word", exp, resp_word)
    endtask

    initial begin
        reset_n = 1'b0;
        div_mant = 6'h01;
        div_exp = 4'h2;
        cycle_start = 3'h0;
        rows = '{'{32'h9cdf_0fc5, 32'h18c0_0c05}, '{32'h9920_fc10, 32'h1920_fc10},
                 '{32'ha212_3abc, 32'h2212_3abc}, '{32'ha8f0_0fff, 32'h2860_0fff},
                 '{32'ha900_0001, 32'h2900_0001}};
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            u_dpc_host_model.cmd(rows[i][0]);
            rd_chk(rows[i][1]);
        end
        `CHK("dith_en0", 1'b1, chan_cfg[0].dith_en)
        `CHK("dith_en2", 1'b0, chan_cfg[2].dith_en)
        `CHK("steps1", 6'h3f, chan_cfg[1].steps)
        `CHK("period0", 16'hfff0, period_cyc[0])
        `CHK("pos_lim2", 18'h02460, pos_lim[2])
        `CHK("neg_lim2", 18'h2a880, neg_lim[2])
        $display("test rows done");
        for (int k = 0; k < 2; k++) begin
            gap = 0;
            do begin
                @(posedge core_clk);
                #1;
                gap++;
            end while (step_tick !== 1'b1 && gap < 100);
        end
        `CHK("tick_gap", 8, gap)
        `CHK("launch_early", 1'b0, launch[0])
        @(posedge core_clk);
        cycle_start <= 3'h1;
        @(posedge core_clk);
        cycle_start <= 3'h0;
        #1;
        gap = 0;
        while (launch[0] !== 1'b1 && gap < 4) begin
            @(posedge core_clk);
            #1;
            gap++;
        end
        `CHK("launch_sync", 1'b1, launch[0])
        u_dpc_host_model.cmd(32'h9a80_0000);
        @(posedge core_clk);
        #1;
        `CHK("launch_free", 1'b1, launch[2])
        $display("test tick and launch done");
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk(32'h1a00_0000);
        rd_chk(32'h2a20_0000);
        u_dpc_host_model.cmd(32'ha3ff_ffff);
        rd_chk(32'h207f_f7ff);
        `CHK("pos_lim0", 18'h0ffe0, pos_lim[0])
        `CHK("gain0", KI_RST, chan_cfg[0].integral_gain_shift)
        u_dpc_host_model.cmd(32'h0000_0000);
        #1;
        `CHK("bad_code", 1'b0, resp_valid)
        $display("test reset and refusals done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
